// ==== shared/csu_pkg.sv ====
package csu_pkg;

    // ------------------------------------------------------------
    // password storage in flash
    // ------------------------------------------------------------
    localparam logic [21:0] PW_BASE_ADDR = 22'h3f7ff8;
    localparam int PW_WORDS = 8;
    localparam int PW_WAIT_STATES = 16;
    localparam logic [2:0] PW_LAST_IDX = 3'h7;

    // ------------------------------------------------------------
    // guarded regions
    // ------------------------------------------------------------
    localparam logic [21:0] FLASH_LO_ADDR = 22'h3e8000;
    localparam logic [21:0] FLASH_HI_ADDR = 22'h3f7fff;
    localparam logic [21:0] OTP_LO_ADDR = 22'h3d7800;
    localparam logic [21:0] OTP_HI_ADDR = 22'h3d7bff;
    localparam logic [21:0] SARAM_LOW_BASE = 22'h008000;
    localparam logic [21:0] SARAM_HIGH_BASE = 22'h009000;
    localparam logic [21:0] SARAM_WORDS = 22'h001000;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic RST_LOCKED = 1'b1;
    localparam logic [127:0] RST_WORDS = 128'h0;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic [2:0] idx;
        logic [15:0] data;
    } csu_key_wr_t;

    typedef struct packed {
        logic rd;
        logic [21:0] addr;
    } csu_dbg_req_t;

    typedef struct packed {
        logic rd;
        logic [21:0] addr;
    } csu_flash_req_t;

    typedef enum logic [1:0] {
        PH_FETCH,
        PH_WAIT,
        PH_RUN
    } csu_phase_t;

endpackage

// ==== verilog/csu_flash_reader.sv ====
`timescale 1ns/1ns
`default_nettype none

module csu_flash_reader #(
    parameter int WAIT = csu_pkg::PW_WAIT_STATES
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic start_i,
    input wire logic [21:0] addr_i,
    input wire logic [15:0] flash_data_i,
    output csu_pkg::csu_flash_req_t flash_req_o,
    output logic done_o,
    output logic [15:0] data_o
);

    localparam int CW = $clog2(WAIT + 1);
    localparam logic [CW-1:0] LAST = CW'(WAIT);

    typedef struct packed {
        logic busy;
        logic [CW-1:0] cnt;
        csu_pkg::csu_flash_req_t req;
        logic done;
        logic [15:0] data;
    } csu_rd_st_t;

    csu_rd_st_t st_r;
    csu_rd_st_t st_nxt;

    // ------------------------------------------------------------
    // fixed wait-state read, independent of flash setting
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        if (!st_r.busy && start_i) begin
            st_nxt.busy = 1'b1;
            st_nxt.cnt = '0;
            st_nxt.req.rd = 1'b1;
            st_nxt.req.addr = addr_i;
        end else if (st_r.busy) begin
            if (st_r.cnt == LAST) begin // see RQ2
                st_nxt.busy = 1'b0;
                st_nxt.req.rd = 1'b0;
                st_nxt.done = 1'b1;
                st_nxt.data = flash_data_i;
            end else begin
                st_nxt.cnt = st_r.cnt + CW'(1);
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign flash_req_o = st_r.req;
    assign done_o = st_r.done;
    assign data_o = st_r.data;

endmodule

`default_nettype wire

// ==== verilog/csu_code_security_unit.sv ====
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// RQ1 - compare against 128-bit password read from flash
// RQ2 - password words read with sixteen fixed wait-states
// RQ3 - one unit guards flash, otp, both rams
// RQ4 - locked: block debug reads of guarded regions, external execution, bootload
// RQ5 - unlock only when written key equals password
// RQ6 - password at top eight words; zeros lock forever
// RQ7 - host zeroes filler words when password programmed
// RQ8 - host keeps reserved data words free of code
// RQ9 - key port sits directly on cpu memory bus
// RQ10 - every reset starts locked until matching key
module csu_code_security_unit #(
    parameter logic [21:0] RAM_LOW_BASE = csu_pkg::SARAM_LOW_BASE,
    parameter logic [21:0] RAM_HIGH_BASE = csu_pkg::SARAM_HIGH_BASE,
    parameter logic [21:0] RAM_WORDS = csu_pkg::SARAM_WORDS
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire csu_pkg::csu_key_wr_t key_wr_i,
    input wire csu_pkg::csu_dbg_req_t dbg_req_i,
    input wire logic [15:0] flash_data_i,
    output csu_pkg::csu_flash_req_t flash_req_o,
    output logic pw_ready_o,
    output logic locked_o,
    output logic perm_locked_o,
    output logic dbg_grant_o,
    output logic dbg_deny_o,
    output logic ext_exec_en_o,
    output logic boot_load_en_o
);

    typedef struct packed {
        csu_pkg::csu_phase_t phase;
        logic [2:0] idx;
        logic [127:0] pw;
        logic [127:0] key;
        logic key_done;
        logic pw_zero;
        logic locked;
        logic dbg_grant;
        logic dbg_deny;
        logic ext_exec_en;
        logic boot_en;
        logic rd_start;
        logic [21:0] rd_addr;
        logic pw_ready;
    } csu_top_st_t;

    csu_top_st_t st_r;
    csu_top_st_t st_nxt;
    logic rd_done;
    logic [15:0] rd_data;
    logic guarded;

    csu_flash_reader #(
        .WAIT(csu_pkg::PW_WAIT_STATES)
    ) u_reader (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .start_i(st_r.rd_start),
        .addr_i(st_r.rd_addr),
        .flash_data_i(flash_data_i),
        .flash_req_o(flash_req_o),
        .done_o(rd_done),
        .data_o(rd_data)
    );

    // ------------------------------------------------------------
    // region decode
    // ------------------------------------------------------------
    always_comb begin
        guarded = 1'b0; // see RQ3
        if (dbg_req_i.addr >= csu_pkg::FLASH_LO_ADDR &&
            dbg_req_i.addr <= csu_pkg::FLASH_HI_ADDR) begin
            guarded = 1'b1;
        end
        if (dbg_req_i.addr >= csu_pkg::OTP_LO_ADDR &&
            dbg_req_i.addr <= csu_pkg::OTP_HI_ADDR) begin
            guarded = 1'b1;
        end
        if (dbg_req_i.addr >= RAM_LOW_BASE &&
            dbg_req_i.addr < RAM_LOW_BASE + RAM_WORDS) begin
            guarded = 1'b1;
        end
        if (dbg_req_i.addr >= RAM_HIGH_BASE &&
            dbg_req_i.addr < RAM_HIGH_BASE + RAM_WORDS) begin
            guarded = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // password fetch, key capture, compare
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.rd_start = 1'b0;
        // key words land directly from the memory bus
        if (key_wr_i.valid) begin // see RQ9
            st_nxt.key[key_wr_i.idx*16 +: 16] = key_wr_i.data;
            if (key_wr_i.idx == csu_pkg::PW_LAST_IDX) begin
                st_nxt.key_done = 1'b1;
            end
        end
        case (st_r.phase)
            csu_pkg::PH_FETCH: begin
                st_nxt.rd_start = 1'b1;
                st_nxt.rd_addr = csu_pkg::PW_BASE_ADDR + {19'h0, st_r.idx};
                st_nxt.phase = csu_pkg::PH_WAIT;
            end
            csu_pkg::PH_WAIT: begin
                if (rd_done) begin
                    st_nxt.pw[st_r.idx*16 +: 16] = rd_data; // see RQ1
                    if (st_r.idx == csu_pkg::PW_LAST_IDX) begin
                        st_nxt.phase = csu_pkg::PH_RUN;
                        st_nxt.pw_ready = 1'b1;
                        st_nxt.pw_zero = (st_nxt.pw == 128'h0); // see RQ6
                    end else begin
                        st_nxt.idx = st_r.idx + 3'h1;
                        st_nxt.phase = csu_pkg::PH_FETCH;
                    end
                end
            end
            csu_pkg::PH_RUN: begin
                if (st_nxt.key_done) begin
                    st_nxt.key_done = 1'b0;
                    st_nxt.locked = st_r.pw_zero ||
                        (st_nxt.key != st_r.pw); // see RQ5
                end
            end
            default: begin
                st_nxt.phase = csu_pkg::PH_FETCH;
            end
        endcase
        st_nxt.ext_exec_en = !st_nxt.locked; // see RQ4
        st_nxt.boot_en = !st_nxt.locked; // see RQ4
        st_nxt.dbg_grant = dbg_req_i.rd && (!guarded || !st_r.locked);
        st_nxt.dbg_deny = dbg_req_i.rd && guarded && st_r.locked; // see RQ4
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r <= '0;
            st_r.phase <= csu_pkg::PH_FETCH;
            st_r.pw <= csu_pkg::RST_WORDS;
            st_r.key <= csu_pkg::RST_WORDS;
            st_r.locked <= csu_pkg::RST_LOCKED; // see RQ10
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pw_ready_o = st_r.pw_ready;
    assign locked_o = st_r.locked;
    assign perm_locked_o = st_r.pw_zero;
    assign dbg_grant_o = st_r.dbg_grant;
    assign dbg_deny_o = st_r.dbg_deny;
    assign ext_exec_en_o = st_r.ext_exec_en;
    assign boot_load_en_o = st_r.boot_en;

endmodule

`default_nettype wire

// ==== test/csu_monitor.sv ====
`timescale 1ns/1ns
`default_nettype none
module csu_monitor #(
    parameter logic [21:0] RAM_LOW_BASE = 22'h0,
    parameter logic [21:0] RAM_HIGH_BASE = 22'h0,
    parameter logic [21:0] RAM_WORDS = 22'h0
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire csu_pkg::csu_key_wr_t key_wr_i,
    input wire csu_pkg::csu_dbg_req_t dbg_req_i,
    input wire csu_pkg::csu_flash_req_t flash_req_o,
    input wire logic pw_ready_o,
    input wire logic locked_o,
    input wire logic perm_locked_o,
    input wire logic dbg_grant_o,
    input wire logic dbg_deny_o,
    input wire logic ext_exec_en_o
);
    // ----------------------------
    // guarded address decode
    // ----------------------------
    logic [21:0] a;
    logic grd;
    assign a = dbg_req_i.addr;
    assign grd = (a >= csu_pkg::FLASH_LO_ADDR && a <= csu_pkg::FLASH_HI_ADDR)
        || (a >= csu_pkg::OTP_LO_ADDR && a <= csu_pkg::OTP_HI_ADDR)
        || (a >= RAM_LOW_BASE && a < RAM_LOW_BASE + RAM_WORDS)
        || (a >= RAM_HIGH_BASE && a < RAM_HIGH_BASE + RAM_WORDS);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_hold;
        (flash_req_o.rd && $stable(flash_req_o.addr))[*8];
    endsequence
    property p_hold;
        $rose(flash_req_o.rd) |=> s_hold ##1 s_hold ##1 !flash_req_o.rd;
    endproperty
    a_hold: assert property (p_hold) else $error("password read length");
    property p_pw_addr;
        flash_req_o.rd |-> flash_req_o.addr[21:3] == csu_pkg::PW_BASE_ADDR[21:3];
    endproperty
    a_pw_addr: assert property (p_pw_addr) else $error("read addr");
    property p_deny;
        dbg_req_i.rd && grd && locked_o |=> dbg_deny_o && !dbg_grant_o;
    endproperty
    a_deny: assert property (p_deny) else $error("guarded read passed");
    property p_grant;
        dbg_req_i.rd && (!grd || !locked_o) |=> dbg_grant_o && !dbg_deny_o;
    endproperty
    a_grant: assert property (p_grant) else $error("open read denied");
    property p_idle;
        !dbg_req_i.rd |=> !dbg_grant_o && !dbg_deny_o;
    endproperty
    a_idle: assert property (p_idle) else $error("stray debug answer");
    property p_ext;
        ext_exec_en_o == !locked_o;
    endproperty
    a_ext: assert property (p_ext) else $error("exec while locked");
    property p_perm;
        perm_locked_o |-> locked_o;
    endproperty
    a_perm: assert property (p_perm) else $error("zero password opened");
    property p_fell;
        $fell(locked_o) |-> pw_ready_o && !perm_locked_o;
    endproperty
    a_fell: assert property (p_fell) else $error("unlock without load");
    property p_keep;
        locked_o && $past(pw_ready_o, 2)
            && !(key_wr_i.valid && key_wr_i.idx == 3'h7) |=> locked_o;
    endproperty
    a_keep: assert property (p_keep) else $error("unlock without key");
endmodule
bind csu_code_security_unit csu_monitor #(.RAM_LOW_BASE(RAM_LOW_BASE),
    .RAM_HIGH_BASE(RAM_HIGH_BASE), .RAM_WORDS(RAM_WORDS)) u_csu_monitor (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .key_wr_i(key_wr_i),
    .dbg_req_i(dbg_req_i), .flash_req_o(flash_req_o),
    .pw_ready_o(pw_ready_o), .locked_o(locked_o),
    .perm_locked_o(perm_locked_o), .dbg_grant_o(dbg_grant_o),
    .dbg_deny_o(dbg_deny_o), .ext_exec_en_o(ext_exec_en_o));
`default_nettype wire

// ==== test/csu_flash_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module csu_flash_model #(
    parameter int LAT = 1
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire csu_pkg::csu_flash_req_t req_i,
    input wire logic [127:0] pw_i,
    output logic [15:0] data_o
);
    logic [4:0] cnt_r;
    logic [15:0] word;
    // filler and reserved words read as zero below the password
    assign word = (req_i.addr >= csu_pkg::PW_BASE_ADDR) ?
        pw_i[{req_i.addr[2:0], 4'h0} +: 16] : 16'h0;
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_r <= 5'h0;
        end else begin
            cnt_r <= req_i.rd ? cnt_r + 5'h1 : 5'h0;
        end
    end
    // invalid data outside the answer window
    assign data_o = (req_i.rd && cnt_r >= LAT) ? word : ~word;
endmodule
`default_nettype wire

// ==== test/csu_code_security_unit_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module csu_code_security_unit_tb;
    localparam logic [127:0] PW = 128'h0123456789abcdeffedcba9876543210;
    localparam logic [21:0] GRD [6] = '{22'h3e8000, 22'h3f7fff, 22'h3d7800,
        22'h3d7bff, 22'h008000, 22'h009fff};
    localparam logic [21:0] OPN [4] = '{22'h3e7fff, 22'h3d7c00, 22'h007fff,
        22'h00a000};
    logic core_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    csu_pkg::csu_key_wr_t key_wr = '0;
    csu_pkg::csu_dbg_req_t dbg_req = '0;
    csu_pkg::csu_flash_req_t flash_req;
    logic [15:0] flash_data;
    logic [127:0] pw = 128'h0;
    logic pw_ready, locked, perm, grant, deny, ext_en, boot_en;
    int mismatches = 0;
    int checks = 0;
    csu_code_security_unit u_csu_code_security_unit (.core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i), .key_wr_i(key_wr), .dbg_req_i(dbg_req),
        .flash_data_i(flash_data), .flash_req_o(flash_req),
        .pw_ready_o(pw_ready), .locked_o(locked), .perm_locked_o(perm),
        .dbg_grant_o(grant), .dbg_deny_o(deny), .ext_exec_en_o(ext_en),
        .boot_load_en_o(boot_en));
    csu_flash_model #(.LAT(16)) u_csu_flash_model (.core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i), .req_i(flash_req), .pw_i(pw), .data_o(flash_data));
    initial forever #5 core_clk_i = ~core_clk_i;
    task automatic chk(input logic seen, input logic exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %b want %b", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        if (mismatches == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic do_reset(input logic [127:0] p);
        pw = p;
        rst_b_i = 1'b0;
        repeat (12) @(negedge core_clk_i);
        chk(locked, 1'b1);
        chk(boot_en, 1'b0);
        rst_b_i = 1'b1;
    endtask
    task automatic write_key(input logic [127:0] k);
        for (int i = 0; i < 8; i++) begin
            @(negedge core_clk_i);
            key_wr = {1'b1, 3'(i), k[16*i +: 16]};
        end
        @(negedge core_clk_i);
        key_wr.valid = 1'b0;
        repeat (2) @(negedge core_clk_i);
    endtask
    task automatic wait_ready(input int least);
        int n;
        n = 0;
        while (pw_ready !== 1'b1 && n < 400) begin
            @(negedge core_clk_i);
            n++;
        end
        chk(pw_ready, 1'b1);
        chk(n >= least, 1'b1);
    endtask
    task automatic dbg(input logic [21:0] a, input logic g);
        @(negedge core_clk_i);
        dbg_req = {1'b1, a};
        @(negedge core_clk_i);
        dbg_req.rd = 1'b0;
        chk(grant, g);
        chk(deny, !g);
    endtask
    task automatic scan(input logic lk);
        foreach (GRD[i]) dbg(GRD[i], !lk);
        foreach (OPN[i]) dbg(OPN[i], 1'b1);
    endtask
    task automatic t_wrong_then_right;
        do_reset(PW);
        wait_ready(136);
        chk(perm, 1'b0);
        scan(1'b1);
        write_key(PW ^ 128'h1);
        chk(locked, 1'b1);
        write_key(PW);
        chk(locked, 1'b0);
        chk(ext_en, 1'b1);
        chk(boot_en, 1'b1);
        scan(1'b0);
    endtask
    task automatic t_early_key;
        do_reset(PW);
        write_key(PW);
        chk(locked, 1'b1);
        wait_ready(100);
        repeat (3) @(negedge core_clk_i);
        chk(locked, 1'b0);
    endtask
    task automatic t_zero_pw;
        do_reset(128'h0);
        wait_ready(136);
        write_key(128'h0);
        chk(locked, 1'b1);
        chk(perm, 1'b1);
        scan(1'b1);
    endtask
    initial begin
        #50000;
        mismatches++;
        tally_and_finish();
    end
    initial begin
        t_wrong_then_right();
        t_early_key();
        t_zero_pw();
        tally_and_finish();
    end
endmodule
`default_nettype wire
